// >>> ppc_top.sv
module ppc_top
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power path comparators
  input wire logic uvlo,
  input wire logic ac_present,
  input wire logic usb_present,
  input wire logic ac_overvoltage_flag,
  input wire logic usb_overvoltage_flag,
  input wire logic rail_short,
  input wire logic bat_overcurrent,
  input wire logic supplement_req,
  input wire logic rail_low,
  // charger comparators
  input wire logic sleep_state,
  input wire logic buck_two_on,
  input wire logic bat_low,
  input wire logic bat_short,
  input wire logic chg_in_short,
  input wire logic at_charge_voltage,
  input wire logic below_term_current,
  input wire logic over_temp,
  input wire logic rail_below_throttle,
  input wire logic thermistor_present,
  input wire logic [11:0] bat_mv,
  // switch drives
  output logic ac_switch_on,
  output logic usb_switch_on,
  output logic bat_switch_on,
  output logic ac_pullup_on,
  output logic usb_pullup_on,
  output logic isrc_on,
  // charger drives
  output logic charger_on,
  output ppc_chg_t chg_phase,
  output ppc_loop_t chg_loop,
  output logic current_reduce,
  output logic bat_short_res_on,
  output logic buck_track,
  output logic [12:0] buck_target_mv,
  output logic [4:0] buck_two_voltage_setting,
  // interrupt
  output logic irq
);
  logic fault;
  logic ac_sw, usb_sw, bat_sw;
  ppc_rec_t rec;
  logic [7:0] ctrl_q;
  logic [1:0] chg_ctrl_q;
  logic [4:0] buck_q;
  logic [PPC_IRQ_W-1:0] irq_stat_q, irq_mask_q, ev;
  logic ac_q, usb_q, ovp_q, chgflt_q;
  ppc_chg_t phase_q, phase_d;
  logic chg_en, chg_fault;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;
  logic [31:0] rd_d;

  assign fault = rail_short | bat_overcurrent;

  ppc_path_sel i_ppc_path_sel (
    .uvlo(uvlo),
    .force_sel(ctrl_q[PPC_CTRL_FORCE_BIT]),
    .usb_susp(ctrl_q[PPC_CTRL_SUSP_BIT]),
    .ac_det(ac_present),
    .usb_det(usb_present),
    .fault(fault),
    .supl_req(supplement_req),
    .ac_sw(ac_sw),
    .usb_sw(usb_sw),
    .bat_sw(bat_sw),
    .rec(rec)
  );

  // switch outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_switch_on <= 1'b0;
      usb_switch_on <= 1'b0;
      bat_switch_on <= 1'b0;
      ac_pullup_on <= 1'b0;
      usb_pullup_on <= 1'b0;
      isrc_on <= 1'b0;
    end else if (clk_en) begin
      ac_switch_on <= ac_sw;
      usb_switch_on <= usb_sw;
      bat_switch_on <= bat_sw;
      ac_pullup_on <= (rec == PPC_REC_AC_RES);
      usb_pullup_on <= (rec == PPC_REC_USB_RES);
      isrc_on <= (rec == PPC_REC_ISRC);
    end
  end

  // charger allowed only with buck two up; sleep-only mode gates on sleep
  assign chg_en = buck_two_on && chg_ctrl_q[PPC_CHG_EN_BIT] && !uvlo
    && (!chg_ctrl_q[PPC_CHG_SLEEP_ONLY_BIT] || sleep_state);
  assign chg_fault = chg_in_short | bat_short;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PPC_CH_OFF: begin
        if (chg_en && !chg_fault) phase_d = PPC_CH_PRE;
      end
      PPC_CH_PRE: begin
        if (!bat_low) phase_d = PPC_CH_CC;
      end
      PPC_CH_CC: begin
        if (bat_low) phase_d = PPC_CH_PRE;
        else if (at_charge_voltage) phase_d = PPC_CH_CV;
      end
      PPC_CH_CV: begin
        if (bat_low) phase_d = PPC_CH_PRE;
        else if (below_term_current) phase_d = PPC_CH_OFF;
      end
      default: phase_d = PPC_CH_OFF;
    endcase
    if (!chg_en || chg_fault) phase_d = PPC_CH_OFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PPC_CH_OFF;
    end else if (clk_en) begin
      phase_q <= phase_d;
    end
  end

  // charger outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charger_on <= 1'b0;
      chg_phase <= PPC_CH_OFF;
      chg_loop <= PPC_LOOP_CUR;
      current_reduce <= 1'b0;
      bat_short_res_on <= 1'b0;
    end else if (clk_en) begin
      charger_on <= (phase_d != PPC_CH_OFF);
      chg_phase <= phase_d;
      current_reduce <= over_temp | rail_below_throttle;
      bat_short_res_on <= bat_short & chg_en;
      if (over_temp || rail_below_throttle) begin
        chg_loop <= PPC_LOOP_THROT;
      end else if (phase_d == PPC_CH_PRE) begin
        chg_loop <= PPC_LOOP_PRE;
      end else if (phase_d == PPC_CH_CV) begin
        chg_loop <= PPC_LOOP_VOLT;
      end else begin
        chg_loop <= PPC_LOOP_CUR;
      end
    end
  end

  // buck two tracking; host setting otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buck_track <= 1'b0;
      buck_target_mv <= '0;
      buck_two_voltage_setting <= PPC_BUCK_RESET;
    end else if (clk_en) begin
      buck_two_voltage_setting <= buck_q;
      // battery-only operation or missing thermistor drops to fixed setting
      if (phase_d == PPC_CH_CC && thermistor_present && !bat_sw && !chg_fault) begin
        buck_track <= 1'b1;
        buck_target_mv <= {1'b0, bat_mv} + PPC_TRACK_OFFSET;
      end else begin
        buck_track <= 1'b0;
        buck_target_mv <= '0;
      end
    end
  end

  // event edges for the interrupt block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_q <= 1'b0;
      usb_q <= 1'b0;
      ovp_q <= 1'b0;
      chgflt_q <= 1'b0;
    end else if (clk_en) begin
      ac_q <= ac_present;
      usb_q <= usb_present;
      ovp_q <= ac_overvoltage_flag | usb_overvoltage_flag;
      chgflt_q <= chg_fault;
    end
  end

  always_comb begin
    ev = '0;
    ev[PPC_EV_FAULT] = fault;
    ev[PPC_EV_AC] = ac_present ^ ac_q;
    ev[PPC_EV_USB] = usb_present ^ usb_q;
    ev[PPC_EV_OVP] = (ac_overvoltage_flag | usb_overvoltage_flag) & ~ovp_q;
    ev[PPC_EV_CHGFLT] = chg_fault & ~chgflt_q;
    ev[PPC_EV_PHASE] = (phase_d != phase_q);
  end

  // axi4-lite write: address and data taken in either order
  assign do_wr = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          PPC_CTRL_OFF, PPC_CHG_CTRL_OFF, PPC_IRQ_STAT_OFF, PPC_IRQ_MASK_OFF,
          PPC_BUCK_OFF: s_axi_bresp <= 2'h0;
          PPC_SW_STAT_OFF, PPC_DET_STAT_OFF, PPC_CHG_STAT_OFF: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PPC_CTRL_RESET;
      chg_ctrl_q <= PPC_CHG_CTRL_RESET;
      buck_q <= PPC_BUCK_RESET;
      irq_mask_q <= '0;
    end else if (clk_en && do_wr && wstrb_q[0]) begin
      case (awaddr_q)
        PPC_CTRL_OFF: ctrl_q <= wdata_q[7:0];
        PPC_CHG_CTRL_OFF: chg_ctrl_q <= wdata_q[1:0];
        PPC_BUCK_OFF: buck_q <= wdata_q[4:0];
        PPC_IRQ_MASK_OFF: irq_mask_q <= wdata_q[PPC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (do_wr && wstrb_q[0] && awaddr_q == PPC_IRQ_STAT_OFF) begin
        irq_stat_q <= (irq_stat_q & ~wdata_q[PPC_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_d = '0;
    case (s_axi_araddr)
      PPC_CTRL_OFF: rd_d[7:0] = ctrl_q;
      PPC_SW_STAT_OFF: rd_d[2:0] = {usb_switch_on, ac_switch_on, bat_switch_on};
      PPC_DET_STAT_OFF: rd_d[4:0] = {usb_overvoltage_flag, ac_overvoltage_flag, usb_present, ac_present, rail_low};
      PPC_CHG_CTRL_OFF: rd_d[1:0] = chg_ctrl_q;
      PPC_CHG_STAT_OFF: rd_d[10:0] = {chg_in_short, bat_short, buck_track,
        current_reduce, chg_loop, charger_on, chg_phase};
      PPC_IRQ_STAT_OFF: rd_d[PPC_IRQ_W-1:0] = irq_stat_q;
      PPC_IRQ_MASK_OFF: rd_d[PPC_IRQ_W-1:0] = irq_mask_q;
      PPC_BUCK_OFF: rd_d[4:0] = buck_q;
      default: rd_d = '0;
    endcase
  end

  // axi4-lite read, one outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= (s_axi_araddr > PPC_BUCK_OFF || s_axi_araddr[1:0] != 2'h0)
          ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ppc_top

// >>> ppc_pkg.sv
package ppc_pkg;
  // register byte offsets
  localparam logic [7:0] PPC_CTRL_OFF = 8'h00;
  localparam logic [7:0] PPC_SW_STAT_OFF = 8'h04;
  localparam logic [7:0] PPC_DET_STAT_OFF = 8'h08;
  localparam logic [7:0] PPC_CHG_CTRL_OFF = 8'h0c;
  localparam logic [7:0] PPC_CHG_STAT_OFF = 8'h10;
  localparam logic [7:0] PPC_IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] PPC_IRQ_MASK_OFF = 8'h18;
  localparam logic [7:0] PPC_BUCK_OFF = 8'h1c;
  // control register fields
  localparam int PPC_CTRL_FORCE_BIT = 0;
  localparam int PPC_CTRL_SUSP_BIT = 7;
  localparam logic [7:0] PPC_CTRL_RESET = 8'h01;
  // charger control fields
  localparam int PPC_CHG_EN_BIT = 0;
  localparam int PPC_CHG_SLEEP_ONLY_BIT = 1;
  localparam logic [1:0] PPC_CHG_CTRL_RESET = 2'h0;
  // buck two default setting, 5-bit code
  localparam logic [4:0] PPC_BUCK_RESET = 5'h10;
  // tracking offset in millivolts
  localparam int PPC_TRACK_OFFSET_MV = 260;
  localparam logic [12:0] PPC_TRACK_OFFSET = 13'(PPC_TRACK_OFFSET_MV);
  // interrupt event bits
  localparam int PPC_IRQ_W = 6;
  localparam int PPC_EV_FAULT = 0;
  localparam int PPC_EV_AC = 1;
  localparam int PPC_EV_USB = 2;
  localparam int PPC_EV_OVP = 3;
  localparam int PPC_EV_CHGFLT = 4;
  localparam int PPC_EV_PHASE = 5;
  // recovery source select
  typedef enum logic [2:0] {
    PPC_REC_NONE = 3'b000,
    PPC_REC_AC_RES = 3'b001,
    PPC_REC_USB_RES = 3'b010,
    PPC_REC_ISRC = 3'b100
  } ppc_rec_t;
  // charger phases
  typedef enum logic [3:0] {
    PPC_CH_OFF = 4'b0001,
    PPC_CH_PRE = 4'b0010,
    PPC_CH_CC = 4'b0100,
    PPC_CH_CV = 4'b1000
  } ppc_chg_t;
  // loop in control of charge current
  typedef enum logic [1:0] {
    PPC_LOOP_CUR = 2'h0,
    PPC_LOOP_VOLT = 2'h1,
    PPC_LOOP_PRE = 2'h2,
    PPC_LOOP_THROT = 2'h3
  } ppc_loop_t;
endpackage : ppc_pkg

// >>> ppc_path_sel.sv
module ppc_path_sel
  import ppc_pkg::*;
(
  // detection and control
  input wire logic uvlo,
  input wire logic force_sel,
  input wire logic usb_susp,
  input wire logic ac_det,
  input wire logic usb_det,
  input wire logic fault,
  input wire logic supl_req,
  // switch decisions
  output logic ac_sw,
  output logic usb_sw,
  output logic bat_sw,
  output ppc_rec_t rec
);
  always_comb begin
    ac_sw = 1'b0;
    usb_sw = 1'b0;
    bat_sw = 1'b0;
    rec = PPC_REC_NONE;
    if (uvlo) begin
      rec = PPC_REC_NONE;
    end else if (fault) begin
      if (ac_det) begin
        rec = PPC_REC_AC_RES;
      end else if (usb_det) begin
        rec = PPC_REC_USB_RES;
      end else begin
        rec = PPC_REC_ISRC;
      end
    end else if (!force_sel) begin
      bat_sw = 1'b1;
    end else if (ac_det) begin
      ac_sw = 1'b1;
      bat_sw = supl_req;
    end else if (usb_det && !usb_susp) begin
      usb_sw = 1'b1;
      bat_sw = supl_req;
    end else begin
      bat_sw = 1'b1;
    end
  end
endmodule : ppc_path_sel

// >>> ppc_properties.sv
module ppc_properties
  import ppc_pkg::*;
(
  // clock and detections
  input wire logic aclk, aresetn, clk_en, uvlo, ac_present, usb_present,
  input wire logic rail_short, bat_overcurrent, charger_on, current_reduce,
  input wire logic [11:0] bat_mv,
  // path and charger drives
  input wire logic ac_switch_on, usb_switch_on, bat_switch_on,
  input wire logic ac_pullup_on, usb_pullup_on, isrc_on, buck_track,
  input wire logic [12:0] buck_target_mv,
  input wire ppc_chg_t chg_phase,
  input wire ppc_loop_t chg_loop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go;
  logic flt;
  assign go = clk_en && !uvlo;
  assign flt = rail_short || bat_overcurrent;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_uvlo_off;
    (clk_en && uvlo) [*2] |-> !(ac_switch_on || usb_switch_on || bat_switch_on || isrc_on);
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("switch on in lockout");
  property p_fault_open;
    go && flt |=> !(ac_switch_on || usb_switch_on || bat_switch_on);
  endproperty
  a_fault_open: assert property (p_fault_open) else $error("switch on in fault");
  property p_rec_ac;
    go && flt && ac_present |=> ac_pullup_on && !usb_pullup_on && !isrc_on;
  endproperty
  a_rec_ac: assert property (p_rec_ac) else $error("wrong recovery, ac");
  property p_rec_isrc;
    go && flt && !ac_present && !usb_present |=> isrc_on && !ac_pullup_on && !usb_pullup_on;
  endproperty
  a_rec_isrc: assert property (p_rec_isrc) else $error("wrong recovery, none");
  property p_no_input;
    go && !flt && !ac_present && !usb_present |=> bat_switch_on && !ac_switch_on;
  endproperty
  a_no_input: assert property (p_no_input) else $error("battery not on");
  property p_track_sum;
    buck_track && $stable(bat_mv) |-> buck_target_mv == 13'(bat_mv) + PPC_TRACK_OFFSET;
  endproperty
  a_track_sum: assert property (p_track_sum) else $error("bad track target");
  property p_pre_loop;
    chg_phase == PPC_CH_PRE && !current_reduce |-> chg_loop == PPC_LOOP_PRE && !buck_track;
  endproperty
  a_pre_loop: assert property (p_pre_loop) else $error("bad pre-charge loop");
  property p_throt;
    charger_on && current_reduce |-> chg_loop == PPC_LOOP_THROT;
  endproperty
  a_throt: assert property (p_throt) else $error("throttle not in control");
  c_fault: cover property (go && flt);
  c_track: cover property (buck_track);
  c_pre: cover property (chg_phase == PPC_CH_PRE);
endmodule : ppc_properties

bind ppc_top ppc_properties i_ppc_properties (
  .aclk, .aresetn, .clk_en, .uvlo, .ac_present, .usb_present, .rail_short,
  .bat_overcurrent, .charger_on, .current_reduce, .bat_mv, .ac_switch_on,
  .usb_switch_on, .bat_switch_on, .ac_pullup_on, .usb_pullup_on, .isrc_on,
  .buck_track, .buck_target_mv, .chg_phase, .chg_loop
);

// >>> ppc_src_model.sv
module ppc_src_model (
  // scenario request
  input wire logic aclk,
  input wire logic [5:0] want,
  // comparator levels
  output logic uvlo,
  output logic ac_present,
  output logic usb_present,
  output logic rail_short,
  output logic bat_overcurrent,
  output logic supplement_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // one edge of lag, like a slow comparator
  always_ff @(posedge aclk) begin
    {uvlo, ac_present, usb_present, rail_short, bat_overcurrent, supplement_req} <= want;
  end
endmodule : ppc_src_model

// >>> power_path_charger_control_bench.sv
module power_path_charger_control_bench
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, clk_en, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ctl;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] want, w, e;
  logic uvlo, ac_present, usb_present, rail_short, bat_overcurrent, supplement_req;
  logic ac_overvoltage_flag, usb_overvoltage_flag, rail_low, sleep_state, buck_two_on, bat_low, bat_short;
  logic chg_in_short, at_charge_voltage, below_term_current, over_temp;
  logic rail_below_throttle, thermistor_present, charger_on, current_reduce;
  logic [11:0] bat_mv;
  logic ac_switch_on, usb_switch_on, bat_switch_on, ac_pullup_on, usb_pullup_on, isrc_on;
  logic bat_short_res_on, buck_track;
  ppc_chg_t chg_phase;
  ppc_loop_t chg_loop;
  logic [12:0] buck_target_mv;
  logic [4:0] buck_two_voltage_setting;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  ppc_top i_ppc_top (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .uvlo, .ac_present, .usb_present, .ac_overvoltage_flag, .usb_overvoltage_flag, .rail_short,
    .bat_overcurrent, .supplement_req, .rail_low, .sleep_state, .buck_two_on, .bat_low,
    .bat_short, .chg_in_short, .at_charge_voltage, .below_term_current, .over_temp,
    .rail_below_throttle, .thermistor_present, .bat_mv, .ac_switch_on, .usb_switch_on,
    .bat_switch_on, .ac_pullup_on, .usb_pullup_on, .isrc_on, .charger_on, .chg_phase,
    .chg_loop, .current_reduce, .bat_short_res_on, .buck_track, .buck_target_mv,
    .buck_two_voltage_setting, .irq
  );
  ppc_src_model i_ppc_src_model (
    .aclk, .want, .uvlo, .ac_present, .usb_present, .rail_short, .bat_overcurrent,
    .supplement_req
  );
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic set_misc(input logic [12:0] v);
    {ac_overvoltage_flag, usb_overvoltage_flag, rail_low, sleep_state, buck_two_on, bat_low, bat_short, chg_in_short,
      at_charge_voltage, below_term_current, over_temp, rail_below_throttle,
      thermistor_present} <= v;
  endtask : set_misc
  // edge first, so no signal is driven twice in one step
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // {ac, usb, bat, ac_res, usb_res, isrc}
  function automatic logic [5:0] exp_path(logic [5:0] v, logic frc, logic sus);
    if (v[5]) return 6'h00;
    if (v[2] || v[1]) return v[4] ? 6'h04 : (v[3] ? 6'h02 : 6'h01);
    if (!frc) return 6'h08;
    if (v[4]) return {2'h2, v[0], 3'h0};
    if (v[3] && !sus) return {2'h1, v[0], 3'h0};
    return 6'h08;
  endfunction : exp_path
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    want = 6'h10;
    bat_mv = 12'h0bb8;
    ctl = PPC_CTRL_RESET;
    set_misc(13'h0000);
    void'($urandom(59));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(PPC_CTRL_OFF);
    chk(rd, 32'(PPC_CTRL_RESET));
    axr(PPC_BUCK_OFF);
    chk(rd, 32'(PPC_BUCK_RESET));
    axr(8'h20);
    chk(rr, 2'h2);
    axw(8'h20, 32'h0000_00ff);
    chk(rr, 2'h2);
    for (int i = 0; i < 150; i++) begin
      if (i % 10 == 5) begin
        ctl = 8'($urandom) & 8'h81;
        axw(PPC_CTRL_OFF, {24'h00_0000, ctl});
      end
      w = 6'($urandom);
      if (i % 3 != 0) w[5] = 1'b0;
      if (i % 2 != 0) w[2:1] = 2'h0;
      want <= w;
      set_misc(13'($urandom));
      repeat (4) @(posedge aclk);
      e = exp_path(w, ctl[0], ctl[7]);
      chk({ac_switch_on, usb_switch_on, bat_switch_on, ac_pullup_on, usb_pullup_on, isrc_on},
        e);
      axr(PPC_SW_STAT_OFF);
      chk(rd, {29'h0, e[4], e[5], e[3]});
      axr(PPC_DET_STAT_OFF);
      chk(rd, {27'h0, usb_overvoltage_flag, ac_overvoltage_flag, w[3], w[4], rail_low});
    end
    // fault event: masked, then unmasked, then cleared
    set_misc(13'h0000);
    axw(PPC_IRQ_MASK_OFF, 32'h0000_0000);
    want <= 6'h14;
    axw(PPC_IRQ_STAT_OFF, 32'h0000_003f);
    want <= 6'h10;
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    axw(PPC_IRQ_MASK_OFF, 32'h0000_0001 << PPC_EV_FAULT);
    repeat (4) @(posedge aclk);
    chk(irq, 1'b1);
    axw(PPC_IRQ_STAT_OFF, 32'h0000_003f);
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    // charger run with sleep-only enable
    // tracking needs the adapter path, so force select back to one
    axw(PPC_CTRL_OFF, 32'h0000_0001);
    chk(rr, 2'h0);
    axw(PPC_BUCK_OFF, 32'h0000_0015);
    s_axi_wstrb <= 4'h0;
    axw(PPC_BUCK_OFF, 32'h0000_0003);
    s_axi_wstrb <= 4'hf;
    axr(PPC_BUCK_OFF);
    chk(rd, 32'h0000_0015);
    chk(buck_two_voltage_setting, 5'h15);
    axw(PPC_CHG_CTRL_OFF, 32'h0000_0003);
    {buck_two_on, bat_low, thermistor_present} <= 3'h7;
    repeat (4) @(posedge aclk);
    chk(charger_on, 1'b0);
    sleep_state <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({charger_on, chg_phase}, {1'b1, PPC_CH_PRE});
    bat_low <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({chg_phase, chg_loop, buck_track}, {PPC_CH_CC, PPC_LOOP_CUR, 1'b1});
    chk(buck_target_mv, 13'(bat_mv) + PPC_TRACK_OFFSET);
    want <= 6'h00;
    repeat (4) @(posedge aclk);
    chk(buck_track, 1'b0);
    want <= 6'h10;
    thermistor_present <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(buck_track, 1'b0);
    thermistor_present <= 1'b1;
    over_temp <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({current_reduce, chg_loop}, {1'b1, PPC_LOOP_THROT});
    over_temp <= 1'b0;
    rail_below_throttle <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(current_reduce, 1'b1);
    rail_below_throttle <= 1'b0;
    at_charge_voltage <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({chg_phase, chg_loop}, {PPC_CH_CV, PPC_LOOP_VOLT});
    below_term_current <= 1'b1;
    // enable still stands, so the cycle restarts one edge after the end
    repeat (2) @(posedge aclk);
    chk({charger_on, chg_phase}, {1'b0, PPC_CH_OFF});
    bat_short <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({bat_short_res_on, charger_on, buck_track}, 3'h4);
    print_verdict();
  end
endmodule : power_path_charger_control_bench
